// ===== hw/atm_params.svh
// Register offsets, reset values and timing constants of the angular timer
`ifndef ATM_PARAMS_SVH
`define ATM_PARAMS_SVH
`define ATM_ADDR_W 4
`define ATM_OFF_CTRL 4'h0
`define ATM_OFF_RES_LO 4'h1
`define ATM_OFF_RES_HI 4'h2
`define ATM_OFF_THRESHOLD_FIELD_LO 4'h3
`define ATM_OFF_THRESHOLD_FIELD_HI 4'h4
`define ATM_OFF_PER_LO 4'h5
`define ATM_OFF_PER_HI 4'h6
`define ATM_OFF_PHS_LO 4'h7
`define ATM_OFF_PHS_HI 4'h8
`define ATM_OFF_ERR_LO 4'h9
`define ATM_OFF_ERR_HI 4'hA
`define ATM_OFF_STAT 4'hB
`define ATM_OFF_MASK 4'hC
`define ATM_CTRL_EN 0
`define ATM_CTRL_MULTI 1
`define ATM_CTRL_POL 2
`define ATM_STAT_PER 0
`define ATM_STAT_PHS 1
`define ATM_STAT_MISS 2
`define ATM_CTRL_RST 8'h00
`define ATM_RES_RST 16'h0000
`define ATM_THRESHOLD_FIELD_RST 15'h0000
`define ATM_GAP_NUM 3
`define ATM_GAP_DEN 2
`endif

// ===== hw/atm_pkg.sv
// Types shared by the angular timer design files
package atm_pkg;
  typedef logic [15:0] atm_count_t;
  typedef logic [14:0] atm_threshold_field_t;
  typedef logic [2:0] atm_evt_t;
endpackage

// ===== hw/atm_divider.sv
// Programmable divider: one-cycle tick every (limit+1) enabled ticks
`timescale 1ns/1ns
module atm_divider
  import atm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic tickIn,
  input wire logic restart,
  input wire atm_count_t limit,
  // Output
  output logic tickOut
);
  atm_count_t cnt_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (restart) begin
      cnt_q <= 16'h0000;
    end else if (tickIn) begin
      if (cnt_q >= limit) begin
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tickOut <= 1'b0;
    end else begin
      tickOut <= tickIn && !restart && (cnt_q >= limit);
    end
  end
endmodule

// ===== hw/atm_irq.sv
// Sticky event flags, write-one-to-clear, with mask and level interrupt
`timescale 1ns/1ns
module atm_irq
  import atm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Events and software access
  input wire atm_evt_t events,
  input wire atm_evt_t clearMask,
  input wire atm_evt_t enableMask,
  // State
  output atm_evt_t status,
  output logic irq
);
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_flag
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          status[i] <= 1'b0;
        end else if (events[i]) begin
          // Set wins over a clear in the same cycle
          status[i] <= 1'b1;
        end else if (clearMask[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~clearMask) | events) & enableMask);
    end
  end
endmodule

// ===== hw/atm_timer.sv
// Angular timer with missing-pulse mode and 15-bit set point
`timescale 1ns/1ns
`include "atm_params.svh"

module atm_timer
  import atm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [`ATM_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData_q,
  // Sensor pulse input
  input wire logic pulseIn,
  // Outputs
  output logic periodClkOut_q,
  output logic phaseClkOut_q,
  output logic irq
);
  logic [7:0] ctrl_q;
  atm_count_t resolutionValue_q;
  atm_threshold_field_t thresholdSetting_q;
  logic [6:0] thresholdUpperBuf_q;
  atm_count_t capturedPeriod_q;
  atm_count_t periodCount_q;
  atm_count_t phaseCount_q;
  atm_count_t sinceCount_q;
  logic signed [16:0] errorTerm_q;
  logic gapSeen_q;
  logic pulseIn_q;
  logic [7:0] rdData_d;
  logic enable;
  logic multiMode;
  logic pulseLevel;
  logic activePulse;
  logic periodTick;
  logic phaseTick;
  logic gapDetect;
  logic firstAfterGap;
  logic latchPeriod;
  logic resetPhase;
  logic [17:0] gapLimit;
  atm_evt_t events;
  atm_evt_t clearMask;
  atm_evt_t enableMask;
  atm_evt_t status;

  function automatic logic wrHit(input logic [`ATM_ADDR_W-1:0] off);
    return regWrite && (regAddr == off);
  endfunction

  assign enable = ctrl_q[`ATM_CTRL_EN];
  assign multiMode = ctrl_q[`ATM_CTRL_MULTI];
  assign pulseLevel = pulseIn ^ ctrl_q[`ATM_CTRL_POL];

  // Rising edge of the active level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulseIn_q <= 1'b0;
    end else begin
      pulseIn_q <= pulseLevel;
    end
  end
  assign activePulse = enable && pulseLevel && !pulseIn_q;

  // Gap threshold: margin above the last period, in module clocks
  assign gapLimit = 18'((({2'b00, capturedPeriod_q} + 18'h00001) *
                   (resolutionValue_q + 16'h0001) * `ATM_GAP_NUM)
                   / `ATM_GAP_DEN);
  assign gapDetect = multiMode && (capturedPeriod_q != 16'h0000) &&
                     ({2'b00, sinceCount_q} > gapLimit);
  assign firstAfterGap = activePulse && (gapSeen_q || gapDetect);
  assign latchPeriod = activePulse && !(multiMode && firstAfterGap);
  // Single-pulse mode resets phase on every pulse
  assign resetPhase = multiMode ? firstAfterGap : activePulse;

  // Time since last pulse and latched gap indication
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sinceCount_q <= 16'h0000;
      gapSeen_q <= 1'b0;
    end else if (!enable || activePulse) begin
      sinceCount_q <= 16'h0000;
      gapSeen_q <= 1'b0;
    end else begin
      if (sinceCount_q != 16'hFFFF) begin
        sinceCount_q <= sinceCount_q + 16'h0001;
      end
      if (gapDetect) begin
        gapSeen_q <= 1'b1;
      end
    end
  end

  atm_divider u_perDiv (
    .mclk(mclk),
    .rst(rst),
    .tickIn(enable),
    .restart(latchPeriod),
    .limit(resolutionValue_q),
    .tickOut(periodTick)
  );

  atm_divider u_phsDiv (
    .mclk(mclk),
    .rst(rst),
    .tickIn(enable),
    .restart(resetPhase),
    .limit(capturedPeriod_q),
    .tickOut(phaseTick)
  );

  // Period counter and capture
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      periodCount_q <= 16'h0000;
      capturedPeriod_q <= 16'h0000;
    end else if (latchPeriod) begin
      capturedPeriod_q <= periodCount_q;
      periodCount_q <= 16'h0000;
    end else if (periodTick && periodCount_q != 16'hFFFF) begin
      periodCount_q <= periodCount_q + 16'h0001;
    end
  end

  // Phase counter: clears on every pulse in single mode, only at a gap in multi mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phaseCount_q <= 16'h0000;
    end else if (resetPhase) begin
      phaseCount_q <= 16'h0000;
    end else if (phaseTick) begin
      phaseCount_q <= phaseCount_q + 16'h0001;
    end
  end

  // Clock outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      periodClkOut_q <= 1'b0;
      phaseClkOut_q <= 1'b0;
    end else begin
      periodClkOut_q <= resetPhase;
      phaseClkOut_q <= phaseTick;
    end
  end

  // Error against set point
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      errorTerm_q <= 17'sh00000;
    end else if (latchPeriod) begin
      errorTerm_q <= $signed({1'b0, periodCount_q}) -
                     $signed({2'b00, thresholdSetting_q});
    end
  end

  // Control, resolution and mask registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `ATM_CTRL_RST;
      resolutionValue_q <= `ATM_RES_RST;
      enableMask <= 3'h0;
    end else begin
      if (wrHit(`ATM_OFF_CTRL)) begin
        ctrl_q <= regWrData;
      end
      if (wrHit(`ATM_OFF_RES_LO)) begin
        resolutionValue_q[7:0] <= regWrData;
      end
      if (wrHit(`ATM_OFF_RES_HI)) begin
        resolutionValue_q[15:8] <= regWrData;
      end
      if (wrHit(`ATM_OFF_MASK)) begin
        enableMask <= regWrData[2:0];
      end
    end
  end

  // Set point with buffered high byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      thresholdUpperBuf_q <= 7'h00;
      thresholdSetting_q <= `ATM_THRESHOLD_FIELD_RST;
    end else begin
      if (wrHit(`ATM_OFF_THRESHOLD_FIELD_HI)) begin
        thresholdUpperBuf_q <= regWrData[6:0];
      end
      if (wrHit(`ATM_OFF_THRESHOLD_FIELD_LO)) begin
        thresholdSetting_q <= {thresholdUpperBuf_q, regWrData};
      end
    end
  end

  assign events = {gapDetect && !gapSeen_q, phaseTick, resetPhase};
  assign clearMask = wrHit(`ATM_OFF_STAT) ? regWrData[2:0] : 3'h0;

  atm_irq u_irq (
    .mclk(mclk),
    .rst(rst),
    .events(events),
    .clearMask(clearMask),
    .enableMask(enableMask),
    .status(status),
    .irq(irq)
  );

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdData_d = 8'h00;
    unique case (regAddr)
      `ATM_OFF_CTRL: rdData_d = ctrl_q;
      `ATM_OFF_RES_LO: rdData_d = resolutionValue_q[7:0];
      `ATM_OFF_RES_HI: rdData_d = resolutionValue_q[15:8];
      `ATM_OFF_THRESHOLD_FIELD_LO: rdData_d = thresholdSetting_q[7:0];
      `ATM_OFF_THRESHOLD_FIELD_HI: rdData_d = {1'b0, thresholdSetting_q[14:8]};
      `ATM_OFF_PER_LO: rdData_d = capturedPeriod_q[7:0];
      `ATM_OFF_PER_HI: rdData_d = capturedPeriod_q[15:8];
      `ATM_OFF_PHS_LO: rdData_d = phaseCount_q[7:0];
      `ATM_OFF_PHS_HI: rdData_d = phaseCount_q[15:8];
      `ATM_OFF_ERR_LO: rdData_d = errorTerm_q[7:0];
      `ATM_OFF_ERR_HI: rdData_d = errorTerm_q[15:8];
      `ATM_OFF_STAT: rdData_d = {5'h00, status};
      `ATM_OFF_MASK: rdData_d = {5'h00, enableMask};
      default: rdData_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdData_q <= 8'h00;
    end else begin
      regRdData_q <= regRead ? rdData_d : 8'h00;
    end
  end

  a_threshold_field_high_zero: assert property (@(posedge mclk) disable iff (rst)
    $past(regRead) && $past(regAddr) == `ATM_OFF_THRESHOLD_FIELD_HI
    |-> !regRdData_q[7]) else $error("set point bit 7 not zero");

  a_threshold_field_buffered: assert property (@(posedge mclk) disable iff (rst)
    wrHit(`ATM_OFF_THRESHOLD_FIELD_HI) && !wrHit(`ATM_OFF_THRESHOLD_FIELD_LO)
    |=> $stable(thresholdSetting_q))
    else $error("high byte moved without low write");

  a_threshold_field_latch: assert property (@(posedge mclk) disable iff (rst)
    wrHit(`ATM_OFF_THRESHOLD_FIELD_LO) |=>
    thresholdSetting_q == {$past(thresholdUpperBuf_q), $past(regWrData)})
    else $error("set point latch wrong");

  a_period_capture: assert property (@(posedge mclk) disable iff (rst)
    latchPeriod |=> capturedPeriod_q == $past(periodCount_q)
    && periodCount_q == 16'h0000) else $error("period not captured");

  a_gap_no_capture: assert property (@(posedge mclk) disable iff (rst)
    multiMode && firstAfterGap |=> $stable(capturedPeriod_q))
    else $error("period captured after gap");

  a_gap_outputs: assert property (@(posedge mclk) disable iff (rst)
    multiMode && firstAfterGap |=> periodClkOut_q && status[0]
    && phaseCount_q == 16'h0000) else $error("gap pulse effects missing");

  a_period_only_gap: assert property (@(posedge mclk) disable iff (rst)
    multiMode && activePulse && !firstAfterGap |=> !periodClkOut_q)
    else $error("period out on ordinary pulse");

  a_phase_tick: assert property (@(posedge mclk) disable iff (rst)
    phaseTick && !resetPhase |=> phaseClkOut_q && status[1]
    && phaseCount_q == $past(phaseCount_q) + 16'h0001)
    else $error("phase tick effects missing");

  a_error_term: assert property (@(posedge mclk) disable iff (rst)
    latchPeriod |=> errorTerm_q == $signed({1'b0, capturedPeriod_q})
    - $signed({2'b00, thresholdSetting_q})) else $error("error wrong");

  // Register port: data only in the cycle after a read
  a_rd_idle_zero: assert property (@(posedge mclk) disable iff (rst)
    !$past(regRead) |-> regRdData_q == 8'h00)
    else $error("read data outside read cycle");

  a_rd_data: assert property (@(posedge mclk) disable iff (rst)
    $past(regRead) |-> regRdData_q == $past(rdData_d))
    else $error("read data differ from register");

  a_threshold_field_upper_buf: assert property (@(posedge mclk) disable iff (rst)
    wrHit(`ATM_OFF_THRESHOLD_FIELD_HI) |=> thresholdUpperBuf_q == $past(regWrData[6:0]))
    else $error("high byte not buffered");

  a_res_write: assert property (@(posedge mclk) disable iff (rst)
    wrHit(`ATM_OFF_RES_LO) |=> resolutionValue_q[7:0] == $past(regWrData))
    else $error("resolution low byte not written");

  // Pulse handling and clock outputs
  a_single_period: assert property (@(posedge mclk) disable iff (rst)
    !multiMode && activePulse |=> periodClkOut_q)
    else $error("single mode pulse gave no period out");

  a_single_phase_reset: assert property (@(posedge mclk) disable iff (rst)
    !multiMode && activePulse |=> phaseCount_q == 16'h0000)
    else $error("single mode phase not cleared");

  a_period_out_src: assert property (@(posedge mclk) disable iff (rst)
    periodClkOut_q |-> $past(resetPhase))
    else $error("period out without phase reset");

  a_phase_out_src: assert property (@(posedge mclk) disable iff (rst)
    phaseClkOut_q |-> $past(phaseTick))
    else $error("phase out without phase tick");

  a_disabled_hold: assert property (@(posedge mclk) disable iff (rst)
    !enable |=> $stable(capturedPeriod_q))
    else $error("period captured while disabled");

  // Counters move only on their own ticks or their restart
  a_period_hold: assert property (@(posedge mclk) disable iff (rst)
    !latchPeriod && !periodTick |=> $stable(periodCount_q))
    else $error("period counter moved without tick");

  a_phase_hold: assert property (@(posedge mclk) disable iff (rst)
    !resetPhase && !phaseTick |=> $stable(phaseCount_q))
    else $error("phase counter moved without tick");

  // Event flags
  a_gap_flag: assert property (@(posedge mclk) disable iff (rst)
    gapDetect && !gapSeen_q |=> status[2])
    else $error("gap flag not set");

  a_flag_set_wins: assert property (@(posedge mclk) disable iff (rst)
    events[0] |=> status[0])
    else $error("period flag lost to clear");
endmodule

// ===== bench/atm_pulse_src.sv
// Toothed-wheel sensor model with an optional missing tooth
`timescale 1ns/1ns
module atm_pulse_src (
  // Clock and command
  input wire logic mclk,
  input wire logic start,
  input wire logic inv,
  input wire logic [15:0] spacing,
  input wire logic [7:0] slots,
  input wire logic [7:0] teeth,
  // Sensor side
  output logic pulseOut
);
  initial begin
    pulseOut = 1'b0;
  end
  // Idle level refreshed every cycle so a polarity change never glitches
  always @(posedge mclk) begin
    pulseOut <= inv;
    if (start) begin
      for (int s = 0; s < slots; s++) begin
        pulseOut <= (teeth == 0 || s % teeth != teeth - 1) ^ inv;
        repeat (2) @(posedge mclk);
        pulseOut <= inv;
        repeat (spacing - 2) @(posedge mclk);
      end
    end
  end
endmodule

// ===== bench/test_atm_timer.sv
// Self-checking bench for the angular timer
`timescale 1ns/1ns
`include "atm_params.svh"
module test_atm_timer;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic start = 1'b0;
  logic inv = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] slots = 8'h00;
  logic [7:0] teeth = 8'h00;
  logic [15:0] spacing = 16'h0030;
  logic [7:0] regRdData_q, d, e, lo, hi;
  logic pulseIn, periodClkOut_q, phaseClkOut_q, irq;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int perCnt = 0;
  int phsCnt = 0;
  int phsRev = 0;
  int pBase, res, per;

  always #10 mclk = ~mclk;

  atm_timer u_atm_timer (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData_q(regRdData_q),
    .pulseIn(pulseIn), .periodClkOut_q(periodClkOut_q),
    .phaseClkOut_q(phaseClkOut_q), .irq(irq)
  );
  atm_pulse_src u_atm_pulse_src (
    .mclk(mclk), .start(start), .inv(inv), .spacing(spacing),
    .slots(slots), .teeth(teeth), .pulseOut(pulseIn)
  );

  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 v = regRdData_q;
  endtask

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  // Period count may land one tick either side of the ideal quotient
  function automatic logic [15:0] near(input int v, input int r);
    return 16'(v >= 48 / (r + 1) - 1 && v <= 48 / (r + 1) + 1);
  endfunction

  task automatic run(input logic [7:0] n, input logic [7:0] t);
    slots <= n;
    teeth <= t;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    repeat (n * spacing + 4) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (phaseClkOut_q === 1'b1)
      phsCnt <= phsCnt + 1;
    if (periodClkOut_q === 1'b1) begin
      perCnt <= perCnt + 1;
      phsRev <= phsCnt;
      phsCnt <= 0;
    end
    if (cyc == 10000) begin
      mismatches++;
      end_sim;
    end
  end

  initial begin
    void'($urandom(44));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), d);
      chk(16'(d), 16'h0000);
    end
    hi = 8'($urandom) | 8'h80;
    lo = 8'($urandom);
    wr(`ATM_OFF_THRESHOLD_FIELD_HI, hi);
    rd(`ATM_OFF_THRESHOLD_FIELD_HI, d);
    chk(16'(d), 16'h0000);
    wr(`ATM_OFF_THRESHOLD_FIELD_LO, lo);
    rd(`ATM_OFF_THRESHOLD_FIELD_HI, d);
    chk(16'(d), 16'(hi & 8'h7F));
    rd(`ATM_OFF_THRESHOLD_FIELD_LO, d);
    chk(16'(d), 16'(lo));
    // Read-only and unmapped places ignore writes
    wr(`ATM_OFF_PER_LO, 8'hFF);
    wr(4'hE, 8'hFF);
    rd(`ATM_OFF_PER_LO, d);
    chk(16'(d), 16'h0000);
    rd(4'hE, d);
    chk(16'(d), 16'h0000);
    for (int p = 0; p < 2; p++) begin
      res = 1 + $urandom % 3;
      inv <= p[0];
      wr(`ATM_OFF_RES_LO, 8'(res));
      wr(`ATM_OFF_CTRL, 8'(1 + 4 * p));
      pBase = perCnt;
      run(6, 0);
      chk(16'(perCnt - pBase), 16'd6);
      rd(`ATM_OFF_PER_LO, d);
      per = d;
      chk(near(per, res), 16'h0001);
      rd(`ATM_OFF_ERR_LO, d);
      rd(`ATM_OFF_ERR_HI, e);
      chk({e, d}, 16'(per - {hi[6:0], lo}));
      wr(`ATM_OFF_CTRL, 8'h00);
    end
    res = 1 + $urandom % 3;
    inv <= 1'b0;
    wr(`ATM_OFF_RES_LO, 8'(res));
    wr(`ATM_OFF_STAT, 8'h07);
    wr(`ATM_OFF_MASK, 8'h01);
    wr(`ATM_OFF_CTRL, 8'h03);
    // Skip the first pulses: the idle time before them may count as a gap
    fork
      run(24, 6);
      begin
        repeat (120) @(posedge mclk);
        pBase = perCnt;
      end
    join
    chk(16'(perCnt - pBase), 16'd3);
    chk(16'(phsRev >= 5 * (res + 1) && phsRev <= 7 * (res + 1)), 1);
    rd(`ATM_OFF_PER_LO, d);
    chk(near(d, res), 16'h0001);
    rd(`ATM_OFF_STAT, d);
    chk(16'(d), 16'h0007);
    chk(16'(irq), 16'h0001);
    wr(`ATM_OFF_MASK, 8'h00);
    tick;
    chk(16'(irq), 16'h0000);
    wr(`ATM_OFF_MASK, 8'h01);
    tick;
    chk(16'(irq), 16'h0001);
    wr(`ATM_OFF_CTRL, 8'h00);
    wr(`ATM_OFF_STAT, 8'h01);
    tick;
    chk(16'(irq), 16'h0000);
    rd(`ATM_OFF_STAT, d);
    chk(16'(d[0]), 16'h0000);
    // Disabled timer ignores the wheel
    pBase = perCnt;
    run(12, 6);
    chk(16'(perCnt - pBase), 16'h0000);
    end_sim;
  end
endmodule
